// ==== logic/bridge_cfg_pkg.sv ====
`default_nettype none
package bridge_cfg_pkg;

	// Request sources
	typedef enum logic [1:0] {
		SRC_EXPRESS = 2'b00,
		SRC_GLOBAL_INDIRECT = 2'b01,
		SRC_SMBUS = 2'b10,
		SRC_EEPROM = 2'b11
	} cfg_source_t;

	// Address regions
	typedef enum logic [1:0] {
		REGION_LEGACY = 2'b00,
		REGION_EXTENDED = 2'b01,
		REGION_VENDOR = 2'b10
	} cfg_region_t;

	////////////////////////////////////////////////////////////////////
	// Region bounds
	localparam logic [11:0] LEGACY_LAST = 12'h0FF;
	localparam logic [11:0] EXTENDED_LAST = 12'h3FF;
	localparam logic [11:0] VENDOR_FIRST = 12'h400;

	////////////////////////////////////////////////////////////////////
	// Legacy header offsets
	localparam logic [11:0] OFF_VENDOR_ID = 12'h000;
	localparam logic [11:0] OFF_DEVICE_ID = 12'h002;
	localparam logic [11:0] OFF_COMMAND_WORD = 12'h004;
	localparam logic [11:0] OFF_PRIMARY_STATUS_WORD = 12'h006;
	localparam logic [11:0] OFF_REVISION_ID = 12'h008;
	localparam logic [11:0] OFF_CLASS_CODE = 12'h009;
	localparam logic [11:0] OFF_CACHE_LINE_SIZE = 12'h00C;
	localparam logic [11:0] OFF_PRIMARY_LATENCY_TIMER = 12'h00D;
	localparam logic [11:0] OFF_HEADER_TYPE = 12'h00E;
	localparam logic [11:0] OFF_BUILTIN_SELF_TEST = 12'h00F;
	localparam logic [11:0] OFF_BASE_ADDRESS_0 = 12'h010;
	localparam logic [11:0] OFF_BASE_ADDRESS_1 = 12'h014;
	localparam logic [11:0] OFF_PRIMARY_BUS_NUMBER = 12'h018;
	localparam logic [11:0] OFF_SECONDARY_BUS_NUMBER = 12'h019;
	localparam logic [11:0] OFF_SUBORDINATE_BUS_NUMBER = 12'h01A;
	localparam logic [11:0] OFF_SECONDARY_LATENCY_TIMER = 12'h01B;
	localparam logic [11:0] OFF_IO_WINDOW_BASE = 12'h01C;
	localparam logic [11:0] OFF_IO_WINDOW_LIMIT = 12'h01D;
	localparam logic [11:0] OFF_SECONDARY_STATUS_WORD = 12'h01E;
	localparam logic [11:0] OFF_MEMORY_WINDOW_BASE = 12'h020;
	localparam logic [11:0] OFF_MEMORY_WINDOW_LIMIT = 12'h022;
	localparam logic [11:0] OFF_PREFETCH_WINDOW_BASE = 12'h024;
	localparam logic [11:0] OFF_PREFETCH_WINDOW_LIMIT = 12'h026;
	localparam logic [11:0] OFF_PREFETCH_WINDOW_BASE_UPPER = 12'h028;
	localparam logic [11:0] OFF_PREFETCH_WINDOW_LIMIT_UPPER = 12'h02C;
	localparam logic [11:0] OFF_IO_WINDOW_BASE_UPPER = 12'h030;
	localparam logic [11:0] OFF_IO_WINDOW_LIMIT_UPPER = 12'h032;
	localparam logic [11:0] OFF_CAPABILITY_LIST_HEAD = 12'h034;
	localparam logic [11:0] OFF_EXPANSION_ROM_BASE = 12'h038;
	localparam logic [11:0] OFF_INTERRUPT_LINE = 12'h03C;
	localparam logic [11:0] OFF_INTERRUPT_PIN = 12'h03D;
	localparam logic [11:0] OFF_BRIDGE_CONTROL = 12'h03E;

	////////////////////////////////////////////////////////////////////
	// Capability structures and register spans
	localparam logic [11:0] OFF_EXPRESS_CAP = 12'h040;
	localparam logic [11:0] OFF_EXPRESS_LAST = 12'h058;
	localparam logic [11:0] OFF_SLOT_CAP = 12'h054;
	localparam logic [11:0] OFF_SLOT_CTL = 12'h058;
	localparam logic [11:0] OFF_EXPRESS2_FIRST = 12'h064;
	localparam logic [11:0] OFF_EXPRESS2_LAST = 12'h078;
	localparam logic [11:0] OFF_SLOT2_CAP = 12'h074;
	localparam logic [11:0] OFF_SLOT2_CTL = 12'h078;
	localparam logic [11:0] OFF_POWER_MGMT_CAP = 12'h0C0;
	localparam logic [11:0] OFF_POWER_MGMT_CSR = 12'h0C4;
	localparam logic [11:0] OFF_MSG_INTR_CAP = 12'h0D0;
	localparam logic [11:0] OFF_MSG_INTR_LAST = 12'h0DC;
	localparam logic [11:0] OFF_SUBSYS_CAP = 12'h0F0;
	localparam logic [11:0] OFF_EXT_INDIRECT_ADDR = 12'h0F8;
	localparam logic [11:0] OFF_EXT_INDIRECT_DATA = 12'h0FC;
	localparam logic [11:0] OFF_ERROR_REPORT_CAP = 12'h100;
	localparam logic [11:0] OFF_ERROR_REPORT_LAST = 12'h128;
	localparam logic [11:0] OFF_SERIAL_NUM_CAP = 12'h180;
	localparam logic [11:0] OFF_SERIAL_NUM_LAST = 12'h188;
	localparam logic [11:0] OFF_VIRT_CHAN_CAP = 12'h200;
	localparam logic [11:0] OFF_VIRT_CHAN_LAST = 12'h210;
	localparam logic [11:0] OFF_POWER_BUDGET_CAP = 12'h280;
	localparam logic [11:0] OFF_POWER_BUDGET_LAST = 12'h28C;
	localparam logic [11:0] OFF_ACCESS_CTRL_CAP = 12'h320;
	localparam logic [11:0] OFF_ACCESS_CTRL_LAST = 12'h328;
	localparam logic [11:0] OFF_MULTICAST_CAP = 12'h330;
	localparam logic [11:0] OFF_MULTICAST_LAST = 12'h35C;

	////////////////////////////////////////////////////////////////////
	// Capability identifiers and reset values
	localparam logic [7:0] ID_EXPRESS = 8'h10;
	localparam logic [7:0] ID_POWER_MGMT = 8'h01;
	localparam logic [7:0] ID_MSG_INTR = 8'h05;
	localparam logic [7:0] ID_SUBSYS = 8'h0D;
	localparam logic [15:0] ID_ERROR_REPORT = 16'h0001;
	localparam logic [15:0] ID_VIRT_CHAN = 16'h0002;
	localparam logic [15:0] ID_SERIAL_NUM = 16'h0003;
	localparam logic [15:0] ID_POWER_BUDGET = 16'h0004;
	localparam logic [15:0] ID_ACCESS_CTRL = 16'h000D;
	localparam logic [15:0] ID_MULTICAST = 16'h0012;
	localparam logic [3:0] EXT_CAP_VERSION = 4'h1;
	localparam logic [23:0] RST_CLASS_CODE = 24'h060400;
	localparam logic [7:0] RST_HEADER_TYPE = 8'h01;
	localparam logic [7:0] LIST_END = 8'h00;
	localparam logic [11:0] EXT_LIST_END = 12'h000;
	localparam logic [7:0] NXT_EXPRESS = 8'hC0;
	localparam logic [7:0] NXT_POWER_MGMT_UP = 8'h00;
	localparam logic [7:0] NXT_POWER_MGMT_DOWN = 8'hD0;
	localparam logic [11:0] NXT_ERROR_REPORT = 12'h200;
	localparam logic [11:0] NXT_VIRT_CHAN_UP = 12'h330;
	localparam logic [11:0] NXT_VIRT_CHAN_DOWN = 12'h320;
	localparam logic [11:0] NXT_ACCESS_CTRL = 12'h330;

endpackage
`default_nettype wire

// ==== logic/bridge_config_space_map.sv ====
// Notes on behaviour
// RQ1: Space reachable from every source, every mode
// RQ2: Refuse extended indirect pair via global pair
// RQ3: Offsets 0x000-0x0FF decode as legacy space
// RQ4: Offsets 0x100-0x3FF decode as extended capabilities
// RQ5: Offsets 0x400-0xFFF hold vendor port registers
// RQ6: Indirect address/data pair reaches extended space
// RQ7: Reserved offsets and regions read zero
// RQ8: Reserved writes complete, change nothing
// RQ9: Slot registers exist only in downstream mode
// RQ10: Absent registers behave exactly as reserved
// RQ11: Defaults link lists; non-link requesters relink pointers
// RQ12: Next pointer zero ends the list
// RQ13: Express capability at 0x040 links to 0x0C0
// RQ14: Power management next: 0 upstream, 0x0D0 downstream
// RQ15: Message interrupt, subsystem capabilities end list
// RQ16: Error reporting at 0x100 links to 0x200
// RQ17: Serial number capability ends extended list
// RQ18: Virtual channel next: 0x330 upstream, 0x320 downstream
// RQ19: Power budgeting capability ends extended list
// RQ20: Access control capability links to 0x330
// RQ21: Multicast capability ends extended list
// RQ22: Registers answer as configuration function 0
// RQ23: Requester uses native or full-dword byte enables
// RQ24: Access decoded as 12-bit byte offset
`timescale 1ns/1ps
`default_nettype none
module bridge_config_space_map #(
	parameter int VENDOR_DWORDS = 16,
	parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
	parameter logic [15:0] DEVICE_ID = 16'h5678, // arbitrary value
	parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Port mode, sampled once after reset
	input wire logic i_port_downstream,
	// Configuration request
	input wire logic i_cfg_req,
	input wire logic i_cfg_write,
	input wire logic [1:0] i_cfg_source,
	input wire logic [2:0] i_cfg_function,
	input wire logic [11:0] i_cfg_offset,
	input wire logic [3:0] i_cfg_byte_en,
	input wire logic [31:0] i_cfg_wdata,
	// Answer
	output logic o_cfg_ack,
	output logic o_cfg_refused,
	output logic [31:0] o_cfg_rdata,
	// Status
	output logic o_ready,
	output logic o_port_downstream
);

	typedef struct packed {
		logic [255:0][31:0] cfg;
		logic [VENDOR_DWORDS-1:0][31:0] vendor;
		logic mode_down;
		logic ready;
		logic ack;
		logic refused;
		logic [31:0] rdata;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [7:0] widx(input logic [11:0] off);
		widx = off[9:2];
	endfunction

	function automatic bridge_cfg_pkg::cfg_region_t region_of(
		input logic [11:0] off);
		if (off <= bridge_cfg_pkg::LEGACY_LAST)
			region_of = bridge_cfg_pkg::REGION_LEGACY; // RQ3
		else if (off <= bridge_cfg_pkg::EXTENDED_LAST)
			region_of = bridge_cfg_pkg::REGION_EXTENDED; // RQ4
		else
			region_of = bridge_cfg_pkg::REGION_VENDOR; // RQ5
	endfunction

	function automatic logic in_span(input logic [11:0] off,
		input logic [11:0] lo, input logic [11:0] hi);
		in_span = (off[11:2] >= lo[11:2]) && (off[11:2] <= hi[11:2]);
	endfunction

	// Presence of a dword in 0x000-0x3FF for the given mode
	function automatic logic present(input logic [11:0] off,
		input logic down);
		logic slot;
		slot = in_span(off, bridge_cfg_pkg::OFF_SLOT_CAP,
				bridge_cfg_pkg::OFF_SLOT_CTL) ||
			in_span(off, bridge_cfg_pkg::OFF_SLOT2_CAP,
				bridge_cfg_pkg::OFF_SLOT2_CTL);
		present = 1'b0;
		if (slot)
			present = down; // RQ9
		else if (in_span(off, bridge_cfg_pkg::OFF_VENDOR_ID,
				bridge_cfg_pkg::OFF_EXPRESS_LAST) ||
			in_span(off, bridge_cfg_pkg::OFF_EXPRESS2_FIRST,
				bridge_cfg_pkg::OFF_EXPRESS2_LAST) ||
			in_span(off, bridge_cfg_pkg::OFF_POWER_MGMT_CAP,
				bridge_cfg_pkg::OFF_POWER_MGMT_CSR) ||
			in_span(off, bridge_cfg_pkg::OFF_SUBSYS_CAP,
				bridge_cfg_pkg::OFF_EXT_INDIRECT_DATA) ||
			in_span(off, bridge_cfg_pkg::OFF_ERROR_REPORT_CAP,
				bridge_cfg_pkg::OFF_ERROR_REPORT_LAST) ||
			in_span(off, bridge_cfg_pkg::OFF_SERIAL_NUM_CAP,
				bridge_cfg_pkg::OFF_SERIAL_NUM_LAST) ||
			in_span(off, bridge_cfg_pkg::OFF_VIRT_CHAN_CAP,
				bridge_cfg_pkg::OFF_VIRT_CHAN_LAST) ||
			in_span(off, bridge_cfg_pkg::OFF_POWER_BUDGET_CAP,
				bridge_cfg_pkg::OFF_POWER_BUDGET_LAST) ||
			in_span(off, bridge_cfg_pkg::OFF_ACCESS_CTRL_CAP,
				bridge_cfg_pkg::OFF_ACCESS_CTRL_LAST) ||
			in_span(off, bridge_cfg_pkg::OFF_MULTICAST_CAP,
				bridge_cfg_pkg::OFF_MULTICAST_LAST))
			present = 1'b1;
		else if (in_span(off, bridge_cfg_pkg::OFF_MSG_INTR_CAP,
				bridge_cfg_pkg::OFF_MSG_INTR_LAST))
			present = down;
	endfunction

	// Writable bits of a stored dword
	function automatic logic [31:0] write_mask(input logic [11:0] off,
		input logic [1:0] src);
		logic link_writer;
		link_writer = (src != bridge_cfg_pkg::SRC_EXPRESS);
		unique case (widx(off))
			widx(bridge_cfg_pkg::OFF_VENDOR_ID),
			widx(bridge_cfg_pkg::OFF_REVISION_ID),
			widx(bridge_cfg_pkg::OFF_CAPABILITY_LIST_HEAD),
			widx(bridge_cfg_pkg::OFF_EXPANSION_ROM_BASE):
				write_mask = 32'h00000000;
			widx(bridge_cfg_pkg::OFF_CACHE_LINE_SIZE):
				write_mask = 32'h000000FF;
			widx(bridge_cfg_pkg::OFF_INTERRUPT_LINE):
				write_mask = 32'hFFFF00FF;
			widx(bridge_cfg_pkg::OFF_EXT_INDIRECT_ADDR):
				write_mask = 32'h00000FFC; // RQ6
			widx(bridge_cfg_pkg::OFF_EXPRESS_CAP),
			widx(bridge_cfg_pkg::OFF_POWER_MGMT_CAP),
			widx(bridge_cfg_pkg::OFF_MSG_INTR_CAP),
			widx(bridge_cfg_pkg::OFF_SUBSYS_CAP):
				write_mask = link_writer ? 32'h0000FF00 : 32'h00000000; // RQ11
			widx(bridge_cfg_pkg::OFF_ERROR_REPORT_CAP),
			widx(bridge_cfg_pkg::OFF_SERIAL_NUM_CAP),
			widx(bridge_cfg_pkg::OFF_VIRT_CHAN_CAP),
			widx(bridge_cfg_pkg::OFF_POWER_BUDGET_CAP),
			widx(bridge_cfg_pkg::OFF_ACCESS_CTRL_CAP),
			widx(bridge_cfg_pkg::OFF_MULTICAST_CAP):
				write_mask = link_writer ? 32'hFFF00000 : 32'h00000000; // RQ11
			default:
				write_mask = 32'hFFFFFFFF;
		endcase
	endfunction

	function automatic logic [31:0] pci_cap(input logic [7:0] nxt,
		input logic [7:0] id);
		pci_cap = {16'h0000, nxt, id};
	endfunction

	function automatic logic [31:0] ext_cap(input logic [11:0] nxt,
		input logic [15:0] id);
		ext_cap = {nxt, bridge_cfg_pkg::EXT_CAP_VERSION, id};
	endfunction

	// Mode independent reset image; mode dependent links load after release
	function automatic state_t reset_state();
		state_t s;
		s = '0;
		s.cfg[widx(bridge_cfg_pkg::OFF_VENDOR_ID)] = {DEVICE_ID, VENDOR_ID};
		s.cfg[widx(bridge_cfg_pkg::OFF_REVISION_ID)] =
			{bridge_cfg_pkg::RST_CLASS_CODE, REVISION};
		s.cfg[widx(bridge_cfg_pkg::OFF_CACHE_LINE_SIZE)] =
			{8'h00, bridge_cfg_pkg::RST_HEADER_TYPE, 16'h0000};
		s.cfg[widx(bridge_cfg_pkg::OFF_CAPABILITY_LIST_HEAD)] =
			{24'h000000, bridge_cfg_pkg::OFF_EXPRESS_CAP[7:0]};
		s.cfg[widx(bridge_cfg_pkg::OFF_EXPRESS_CAP)] = pci_cap(
			bridge_cfg_pkg::NXT_EXPRESS, bridge_cfg_pkg::ID_EXPRESS); // RQ13
		s.cfg[widx(bridge_cfg_pkg::OFF_POWER_MGMT_CAP)] = pci_cap(
			bridge_cfg_pkg::NXT_POWER_MGMT_UP,
			bridge_cfg_pkg::ID_POWER_MGMT); // RQ14
		s.cfg[widx(bridge_cfg_pkg::OFF_MSG_INTR_CAP)] = pci_cap(
			bridge_cfg_pkg::LIST_END, bridge_cfg_pkg::ID_MSG_INTR); // RQ15
		s.cfg[widx(bridge_cfg_pkg::OFF_SUBSYS_CAP)] = pci_cap(
			bridge_cfg_pkg::LIST_END, bridge_cfg_pkg::ID_SUBSYS); // RQ15
		s.cfg[widx(bridge_cfg_pkg::OFF_ERROR_REPORT_CAP)] = ext_cap(
			bridge_cfg_pkg::NXT_ERROR_REPORT,
			bridge_cfg_pkg::ID_ERROR_REPORT); // RQ16
		s.cfg[widx(bridge_cfg_pkg::OFF_SERIAL_NUM_CAP)] = ext_cap(
			bridge_cfg_pkg::EXT_LIST_END,
			bridge_cfg_pkg::ID_SERIAL_NUM); // RQ17
		s.cfg[widx(bridge_cfg_pkg::OFF_VIRT_CHAN_CAP)] = ext_cap(
			bridge_cfg_pkg::NXT_VIRT_CHAN_UP,
			bridge_cfg_pkg::ID_VIRT_CHAN); // RQ18
		s.cfg[widx(bridge_cfg_pkg::OFF_POWER_BUDGET_CAP)] = ext_cap(
			bridge_cfg_pkg::EXT_LIST_END,
			bridge_cfg_pkg::ID_POWER_BUDGET); // RQ19
		s.cfg[widx(bridge_cfg_pkg::OFF_ACCESS_CTRL_CAP)] = ext_cap(
			bridge_cfg_pkg::NXT_ACCESS_CTRL,
			bridge_cfg_pkg::ID_ACCESS_CTRL); // RQ20
		s.cfg[widx(bridge_cfg_pkg::OFF_MULTICAST_CAP)] = ext_cap(
			bridge_cfg_pkg::EXT_LIST_END,
			bridge_cfg_pkg::ID_MULTICAST); // RQ21 RQ12
		reset_state = s;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Decode

	logic is_indirect_pair;
	logic refuse;
	logic [11:0] eff_off;
	logic hit_cfg;
	logic hit_vendor;
	logic [11:0] vendor_idx;
	logic [31:0] bmask;
	logic [31:0] wmask;

	always_comb begin
		is_indirect_pair = (i_cfg_offset[11:2] ==
				bridge_cfg_pkg::OFF_EXT_INDIRECT_ADDR[11:2]) ||
			(i_cfg_offset[11:2] ==
				bridge_cfg_pkg::OFF_EXT_INDIRECT_DATA[11:2]);
		refuse = is_indirect_pair &&
			(i_cfg_source == bridge_cfg_pkg::SRC_GLOBAL_INDIRECT); // RQ2
		eff_off = i_cfg_offset; // RQ24
		if (i_cfg_offset[11:2] ==
				bridge_cfg_pkg::OFF_EXT_INDIRECT_DATA[11:2])
			eff_off = {state_ff.cfg[widx(
				bridge_cfg_pkg::OFF_EXT_INDIRECT_ADDR)][11:2], 2'b00}; // RQ6
		vendor_idx = {2'b00,
			eff_off[11:2] - bridge_cfg_pkg::VENDOR_FIRST[11:2]};
		hit_cfg = (region_of(eff_off) != bridge_cfg_pkg::REGION_VENDOR) &&
			present(eff_off, state_ff.mode_down) &&
			(eff_off[11:2] !=
				bridge_cfg_pkg::OFF_EXT_INDIRECT_DATA[11:2]) &&
			(i_cfg_function == 3'h0); // RQ22 RQ10
		hit_vendor = (region_of(eff_off) == bridge_cfg_pkg::REGION_VENDOR) &&
			(vendor_idx < 12'(VENDOR_DWORDS)) &&
			(i_cfg_function == 3'h0); // RQ5
		bmask = {{8{i_cfg_byte_en[3]}}, {8{i_cfg_byte_en[2]}},
			{8{i_cfg_byte_en[1]}}, {8{i_cfg_byte_en[0]}}}; // RQ23
		wmask = bmask & write_mask(eff_off, i_cfg_source);
	end

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_state = state_ff;
		nxt_state.ack = 1'b0;
		nxt_state.refused = 1'b0;
		nxt_state.rdata = 32'h00000000;
		if (!state_ff.ready) begin
			nxt_state.ready = 1'b1;
			nxt_state.mode_down = i_port_downstream;
			nxt_state.cfg[widx(bridge_cfg_pkg::OFF_POWER_MGMT_CAP)][15:8] =
				i_port_downstream ? bridge_cfg_pkg::NXT_POWER_MGMT_DOWN :
				bridge_cfg_pkg::NXT_POWER_MGMT_UP; // RQ14
			nxt_state.cfg[widx(bridge_cfg_pkg::OFF_VIRT_CHAN_CAP)][31:20] =
				i_port_downstream ? bridge_cfg_pkg::NXT_VIRT_CHAN_DOWN :
				bridge_cfg_pkg::NXT_VIRT_CHAN_UP; // RQ18
		end else if (i_cfg_req) begin
			nxt_state.ack = 1'b1; // RQ1
			if (refuse) begin
				nxt_state.refused = 1'b1; // RQ2
			end else if (!i_cfg_write) begin
				if (hit_cfg)
					nxt_state.rdata = state_ff.cfg[widx(eff_off)];
				else if (hit_vendor)
					nxt_state.rdata = state_ff.vendor[vendor_idx];
				else
					nxt_state.rdata = 32'h00000000; // RQ7
			end else if (hit_cfg) begin
				nxt_state.cfg[widx(eff_off)] =
					(state_ff.cfg[widx(eff_off)] & ~wmask) |
					(i_cfg_wdata & wmask);
			end else if (hit_vendor) begin
				nxt_state.vendor[vendor_idx] =
					(state_ff.vendor[vendor_idx] & ~bmask) |
					(i_cfg_wdata & bmask);
			end
			// Any other write completes and stores nothing RQ8
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			state_ff <= reset_state();
		else
			state_ff <= nxt_state;
	end

	assign o_cfg_ack = state_ff.ack;
	assign o_cfg_refused = state_ff.refused;
	assign o_cfg_rdata = state_ff.rdata;
	assign o_ready = state_ff.ready;
	assign o_port_downstream = state_ff.mode_down;

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	chk_request_answered: assert property ( // RQ1
		i_cfg_req && o_ready |=> o_cfg_ack)
		else $error("request not answered next cycle");

	chk_no_stray_ack: assert property ( // RQ1
		!(i_cfg_req && o_ready) |=> !o_cfg_ack && !o_cfg_refused &&
			o_cfg_rdata == 32'h00000000)
		else $error("answer without a taken request");

	chk_indirect_refused: assert property ( // RQ2
		i_cfg_req && o_ready && i_cfg_source == 2'b01 &&
		i_cfg_offset[11:3] == 9'h01F |=> o_cfg_refused &&
			o_cfg_rdata == 32'h00000000 && $stable(state_ff.cfg))
		else $error("indirect pair reached via global pair");

	chk_refused_only_pair: assert property ( // RQ2
		i_cfg_req && o_ready && (i_cfg_source != 2'b01 ||
		i_cfg_offset[11:3] != 9'h01F) |=> !o_cfg_refused)
		else $error("access refused outside the indirect pair");

	chk_reserved_read: assert property ( // RQ7
		i_cfg_req && o_ready && !i_cfg_write && !hit_cfg && !hit_vendor
		|=> o_cfg_ack && o_cfg_rdata == 32'h00000000)
		else $error("reserved read not zero");

	chk_reserved_write: assert property ( // RQ8
		i_cfg_req && o_ready && i_cfg_write && !hit_cfg && !hit_vendor
		|=> o_cfg_ack && $stable(state_ff.cfg) && $stable(state_ff.vendor))
		else $error("reserved write changed state");

	chk_slot_absent_upstream: assert property ( // RQ9
		i_cfg_req && o_ready && !o_port_downstream && !i_cfg_write &&
		i_cfg_source != 2'b01 &&
		i_cfg_offset[11:2] == bridge_cfg_pkg::OFF_SLOT_CAP[11:2]
		|=> o_cfg_rdata == 32'h00000000)
		else $error("slot register visible upstream");

	chk_other_function: assert property ( // RQ22
		i_cfg_req && o_ready && !i_cfg_write && i_cfg_function != 3'h0
		|=> o_cfg_rdata == 32'h00000000)
		else $error("function other than zero answered");

	chk_mode_held: assert property ( // RQ9
		o_ready |=> o_ready && $stable(o_port_downstream))
		else $error("port mode changed without reset");

	chk_express_link: assert property ( // RQ13
		$rose(o_ready) |-> state_ff.cfg[16][15:8] == 8'hC0)
		else $error("express capability next pointer wrong");

	chk_power_mgmt_link: assert property ( // RQ14
		$rose(o_ready) |-> state_ff.cfg[48][15:8] ==
			(o_port_downstream ? 8'hD0 : 8'h00))
		else $error("power management next pointer wrong");

	chk_error_report_link: assert property ( // RQ16
		$rose(o_ready) |-> state_ff.cfg[64][31:20] == 12'h200)
		else $error("error reporting next pointer wrong");

	chk_virt_chan_link: assert property ( // RQ18
		$rose(o_ready) |-> state_ff.cfg[128][31:20] ==
			(o_port_downstream ? 12'h320 : 12'h330))
		else $error("virtual channel next pointer wrong");

	chk_multicast_end: assert property ( // RQ21
		$rose(o_ready) |-> state_ff.cfg[204][31:20] == 12'h000 &&
			state_ff.cfg[200][31:20] == 12'h330)
		else $error("extended list tail wrong");

	chk_ready_one_edge: assert property ( // RQ11
		$fell(i_reset) |-> !o_ready ##1 o_ready)
		else $error("ready not raised after first edge");

endmodule // bridge_config_space_map
`default_nettype wire

// ==== dv/cfg_requester.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfg_requester (
	// Clock
	input wire logic i_core_clk,
	// Request to the bridge
	output logic o_req,
	output logic o_write,
	output logic [1:0] o_source,
	output logic [2:0] o_function,
	output logic [11:0] o_offset,
	output logic [3:0] o_byte_en,
	output logic [31:0] o_wdata,
	// Answer from the bridge
	input wire logic i_ack,
	input wire logic i_refused,
	input wire logic [31:0] i_rdata
);
	initial begin
		o_req = 1'b0;
		o_write = 1'b0;
		o_source = 2'h0;
		o_function = 3'h0;
		o_offset = 12'h000;
		o_byte_en = 4'h0;
		o_wdata = 32'h0;
	end

	////////////////////////////////////////////////////////////////////
	// One request, answer taken at the following edge
	task automatic xfer(input logic [1:0] s, input logic [2:0] f,
		input logic w, input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] d, input int gap,
		output logic [31:0] rd, output logic rf, output logic ok);
		repeat (gap + 1) @(posedge i_core_clk);
		o_req <= 1'b1;
		o_write <= w;
		o_source <= s;
		o_function <= f;
		o_offset <= a;
		o_byte_en <= be;
		o_wdata <= d;
		@(posedge i_core_clk);
		o_req <= 1'b0;
		o_offset <= ~a;
		o_wdata <= ~d;
		@(posedge i_core_clk);
		ok = i_ack;
		rd = i_rdata;
		rf = i_refused;
	endtask
endmodule // cfg_requester
`default_nettype wire

// ==== dv/bridge_config_space_map_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module bridge_config_space_map_tb;
	localparam logic [31:0] IDS = 32'h5AC3_A5A5;
	logic i_core_clk, i_reset, i_port_downstream;
	logic req, wr_en, ack, refused, ready, mode;
	logic [1:0] src;
	logic [2:0] fn;
	logic [11:0] off, nx;
	logic [3:0] be;
	logic [31:0] wdata, rdata, rdv;
	logic refd;
	int n_fail, samples_checked, k;
	logic [11:0] cap_off [10] = '{12'h040, 12'h0C0, 12'h0D0, 12'h0F0,
		12'h100, 12'h180, 12'h200, 12'h280, 12'h320, 12'h330};
	logic [15:0] cap_id [10] = '{16'h10, 16'h01, 16'h05, 16'h0D, 16'h01,
		16'h03, 16'h02, 16'h04, 16'h0D, 16'h12};
	logic [11:0] link_up [10] = '{12'h0C0, 12'h000, 12'h000, 12'h000,
		12'h200, 12'h000, 12'h330, 12'h000, 12'h330, 12'h000};
	logic [11:0] link_down [10] = '{12'h0C0, 12'h0D0, 12'h000, 12'h000,
		12'h200, 12'h000, 12'h320, 12'h000, 12'h330, 12'h000};

	bridge_config_space_map #(.VENDOR_ID(IDS[15:0]),
		.DEVICE_ID(IDS[31:16])) bridge_config_space_map_i (
		.i_core_clk(i_core_clk), .i_reset(i_reset),
		.i_port_downstream(i_port_downstream), .i_cfg_req(req),
		.i_cfg_write(wr_en), .i_cfg_source(src), .i_cfg_function(fn),
		.i_cfg_offset(off), .i_cfg_byte_en(be), .i_cfg_wdata(wdata),
		.o_cfg_ack(ack), .o_cfg_refused(refused), .o_cfg_rdata(rdata),
		.o_ready(ready), .o_port_downstream(mode));

	cfg_requester cfg_requester_i (.i_core_clk(i_core_clk), .o_req(req),
		.o_write(wr_en), .o_source(src), .o_function(fn), .o_offset(off),
		.o_byte_en(be), .o_wdata(wdata), .i_ack(ack), .i_refused(refused),
		.i_rdata(rdata));

	always #50 i_core_clk = ~i_core_clk;

	////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic acc(input logic [1:0] s, input logic [2:0] f,
		input logic w, input logic [11:0] a, input logic [3:0] b,
		input logic [31:0] d);
		logic ok;
		cfg_requester_i.xfer(s, f, w, a, b, d, samples_checked % 3, rdv,
			refd, ok);
		if (ok !== 1'b1) begin
			n_fail++;
			$display("wrong value ack exp 1 got %b", ok);
			test_done();
		end
	endtask

	task automatic wr(input logic [1:0] s, input logic [11:0] a,
		input logic [31:0] d);
		acc(s, 3'h0, 1'b1, a, 4'hF, d);
	endtask

	task automatic rchk(input string nm, input logic [1:0] s,
		input logic [2:0] f, input logic [11:0] a, input logic [31:0] e);
		acc(s, f, 1'b0, a, 4'hF, 32'h0);
		`CHK(nm, e, rdv);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		i_core_clk = 1'b0;
		i_reset = 1'b1;
		i_port_downstream = 1'b0;
		n_fail = 0;
		samples_checked = 0;
		for (int m = 0; m < 2; m++) begin
			i_reset <= 1'b1;
			i_port_downstream <= m[0];
			repeat (6) @(posedge i_core_clk);
			`CHK("ready in reset", 0, ready);
			i_reset <= 1'b0;
			k = 0;
			while (ready !== 1'b1 && k < 8) begin
				@(posedge i_core_clk);
				k++;
			end
			`CHK("ready", 1, ready);
			if (ready !== 1'b1)
				test_done();
			`CHK("mode", m[0], mode);
			for (int i = 0; i < 10; i++) begin
				nx = m[0] ? link_down[i] : link_up[i];
				acc(2'h0, 3'h0, 1'b0, cap_off[i], 4'hF, 32'h0);
				if (i == 2 && !m[0])
					`CHK("msi", 0, rdv);
				else if (i < 4)
					`CHK("cap", {nx[7:0], cap_id[i][7:0]}, rdv[15:0]);
				else if (i < 7)
					`CHK("ecap", {nx, 4'h1, cap_id[i]}, rdv);
				else
					`CHK("ecap", {nx, 4'h1, cap_id[i]}, rdv);
			end
			rchk("ids", 2'h0, 3'h0, 12'h000, IDS);
			rchk("other fn", 2'h0, 3'h1, 12'h000, 32'h0);
			rchk("lane", 2'h0, 3'h0, 12'h003, IDS);
			wr(2'h0, 12'h054, 32'hC3A5_5A3C);
			rchk("slot", 2'h0, 3'h0, 12'h054, m[0] ? 32'hC3A5_5A3C : 0);
			wr(2'h0, 12'h010, 32'h1357_9BDF);
			wr(2'h0, 12'h0E0, 32'hFFFF_FFFF);
			`CHK("rsv refused", 0, refd);
			rchk("rsv", 2'h0, 3'h0, 12'h0E0, 32'h0);
			rchk("bar", 2'h0, 3'h0, 12'h010, 32'h1357_9BDF);
			wr(2'h0, 12'h104, 32'h2468_ACE0);
			rchk("ext", 2'h0, 3'h0, 12'h104, 32'h2468_ACE0);
			wr(2'h0, 12'h400, 32'h0F1E_2D3C);
			rchk("vendor", 2'h0, 3'h0, 12'h400, 32'h0F1E_2D3C);
			rchk("vendor rsv", 2'h0, 3'h0, 12'hFFC, 32'h0);
			wr(2'h0, 12'h018, 32'h0);
			acc(2'h0, 3'h0, 1'b1, 12'h018, 4'h2, 32'hFFFF_FFFF);
			rchk("lanes", 2'h0, 3'h0, 12'h018, 32'h0000_FF00);
			wr(2'h0, 12'h0F8, 32'h0000_0104);
			wr(2'h0, 12'h0FC, 32'h7E81_18E7);
			rchk("indirect", 2'h0, 3'h0, 12'h104, 32'h7E81_18E7);
			rchk("ind data", 2'h0, 3'h0, 12'h0FC, 32'h7E81_18E7);
			wr(2'h1, 12'h0F8, 32'h0000_0400);
			`CHK("refused", 1, refd);
			rchk("refused rd", 2'h1, 3'h0, 12'h0FC, 32'h0);
			`CHK("refused", 1, refd);
			rchk("ind kept", 2'h0, 3'h0, 12'h0FC, 32'h7E81_18E7);
			for (int s = 0; s < 4; s++) begin
				rchk("src ids", s[1:0], 3'h0, 12'h000, IDS);
				wr(s[1:0], 12'h014, {28'h0, s[3:0]});
				rchk("src bar", 2'h0, 3'h0, 12'h014, s);
			end
			acc(2'h2, 3'h0, 1'b1, 12'h0C0, 4'h2, 32'h0000_F000);
			acc(2'h0, 3'h0, 1'b0, 12'h0C0, 4'hF, 32'h0);
			`CHK("relink", 8'hF0, rdv[15:8]);
			acc(2'h0, 3'h0, 1'b1, 12'h040, 4'h2, 32'h0);
			acc(2'h0, 3'h0, 1'b0, 12'h040, 4'hF, 32'h0);
			`CHK("link ro", 8'hC0, rdv[15:8]);
		end
		test_done();
	end
endmodule // bridge_config_space_map_tb
`default_nettype wire
